// ---- design/cis_defs.vh ----
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH
// register offsets on the byte-wide register port
`define CIS_ADDR_W          8
`define CIS_OFF_IDENT       8'h00
`define CIS_OFF_REF_FLAGS   8'h02
`define CIS_OFF_PLL_FLAGS   8'h03
`define CIS_OFF_REF_EN      8'h04
`define CIS_OFF_PLL_EN      8'h05
`define CIS_OFF_REV_EXT     8'hC6
// field positions
`define CIS_ID_LSB          0
`define CIS_ID_MSB          4
`define CIS_REV_LSB         5
`define CIS_REV_MSB         6
`define CIS_READY_BIT       7
`define CIS_BIT_A           0
`define CIS_BIT_B           1
// event bit order inside the synchroniser word
`define CIS_EVT_REF_A       0
`define CIS_EVT_REF_B       1
`define CIS_EVT_HOLD        2
`define CIS_EVT_UNLOCK      3
// reset values
`define CIS_EN_RST          2'h0
`define CIS_FLAG_RST        2'h0
`define CIS_REV_EXT_RST     8'h03
`define CIS_SYNC_RST        4'h0
`define CIS_RDATA_RST       8'h00
`define CIS_RSV_ZERO        6'h00
// timing: ready deadline 50 ms, host polls no earlier than 40 ms
`define CIS_CLK_MHZ         200
`define CIS_READY_MAX_MS    50
`define CIS_POLL_MIN_MS     40
// 40 ms of 200 MHz clocks, inside the 50 ms limit
`define CIS_READY_CYCLES    24'h7A1200
`endif

// ---- design/cis_ready_timer.v ----
`timescale 1ns/100ps
`include "cis_defs.vh"
// counts from reset release and raises ready once done
module cis_ready_timer #(
  parameter             CNT_W  = 24,
  // default matches the top level: 40 ms at 200 MHz
  parameter [CNT_W-1:0] CYCLES = `CIS_READY_CYCLES
) (
  // clock and reset
  input  wire       mclk,
  input  wire       srst,
  input  wire       ce,
  // status
  output reg        ready
);
  reg  [CNT_W-1:0]  count;

  // saturating count; ready stays high until the next reset
  always @(posedge mclk) begin
    if (srst) begin
      count <= {CNT_W{1'h0}};
      ready <= 1'h0;
    end else if (ce && !ready) begin
      if (count >= CYCLES - 1'h1)
        ready <= 1'h1;
      else
        count <= count + 1'h1;
    end
  end
endmodule // cis_ready_timer

// ---- design/cis_ident_irq.v ----
`timescale 1ns/100ps
`include "cis_defs.vh"
// Notes on behaviour
// RULE1 - identity holds part code and revision
// RULE2 - ready bit rises within 50 ms
// RULE3 - host waits 40 ms, programs after ready
// RULE4 - input a failure sets flag when enabled
// RULE5 - input b failure sets flag when enabled
// RULE6 - holdover sets pll flag when enabled
// RULE7 - loss of lock sets flag when enabled
// RULE8 - reference enables at bits 0 and 1
// RULE9 - pll enables at bits 0 and 1
// RULE10 - flags sticky until cleared, irq follows
module cis_ident_irq #(
  parameter [4:0] PART_ID      = 5'h0A, // arbitrary value
  parameter [1:0] REVISION     = 2'h0,
  // ready counter width; 24 bits hold more than 50 ms of clocks
  parameter       CNT_W        = 24,
  // ready delay; default 40 ms at 200 MHz, inside the 50 ms limit
  parameter       READY_CYCLES = `CIS_READY_CYCLES
) (
  // clock, reset, clock enable
  input  wire       mclk,
  input  wire       srst,
  input  wire       ce,
  // register port (same clock domain)
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // event inputs from monitors, asynchronous to mclk
  input  wire       ref_a_fail,
  input  wire       ref_b_fail,
  input  wire       pll_holdover,
  input  wire       pll_unlock,
  // interrupt request
  output wire       irq
);
  // ****************************************************
  // helper functions
  // ****************************************************
  // address match, shared by the write strobes and the read mux
  function addr_hit;
    input [`CIS_ADDR_W-1:0] addr;
    input [`CIS_ADDR_W-1:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // sticky flag update; the set term is or-ed last so an event
  // landing in the clearing cycle is never lost
  function [1:0] flag_update;
    input [1:0] flags;
    input [1:0] clear;
    input [1:0] events;
    input [1:0] enables;
    begin
      flag_update = (flags & ~clear) | (events & enables);
    end
  endfunction

  // ****************************************************
  // event synchronisers
  // ****************************************************
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] evt_prev;
  wire [3:0] evt_rise;
  wire [1:0] ref_rise;
  wire [1:0] pll_rise;

  // two flops per event; rising edge taken from the second stage only
  // a pin already high at reset release counts as one event
  always @(posedge mclk) begin
    if (srst) begin
      sync1    <= `CIS_SYNC_RST;
      sync2    <= `CIS_SYNC_RST;
      evt_prev <= `CIS_SYNC_RST;
    end else if (ce) begin
      sync1    <= {pll_unlock, pll_holdover, ref_b_fail, ref_a_fail};
      sync2    <= sync1;
      evt_prev <= sync2;
    end
  end
  assign evt_rise = sync2 & ~evt_prev;
  // split by register: {b, a} and {unlock, holdover}
  assign ref_rise = evt_rise[`CIS_EVT_REF_B:`CIS_EVT_REF_A];
  assign pll_rise = evt_rise[`CIS_EVT_UNLOCK:`CIS_EVT_HOLD];

  // ****************************************************
  // ready timer
  // ****************************************************
  wire ready;

  // RULE2 ready after delay
  // ce low stretches the delay; the count restarts on every reset
  cis_ready_timer #(
    .CNT_W  (CNT_W),
    .CYCLES (READY_CYCLES)
  ) u_ready (
    .mclk  (mclk),
    .srst  (srst),
    .ce    (ce),
    .ready (ready)
  );

  // ****************************************************
  // enables and sticky flags
  // ****************************************************
  // storage; bits 7:2 of the enable and flag registers are not kept and read as zero
  reg  [1:0] input_failure_enable;  // {b, a}
  reg  [1:0] loop_enable;           // {unlock, holdover}
  reg  [1:0] input_failure_flags;   // {b, a}
  reg  [1:0] loop_flags;            // {unlock, holdover}
  reg  [7:0] rev_ext;
  wire       wr_ref_flags;
  wire       wr_pll_flags;
  wire       wr_ref_en;
  wire       wr_pll_en;
  wire       wr_rev_ext;
  wire [1:0] clr_ref_flags;
  wire [1:0] clr_pll_flags;
  wire [1:0] next_ref_flags;
  wire [1:0] next_pll_flags;

  // write strobes; identity and unmapped offsets match none, so are ignored
  assign wr_ref_flags = reg_wr && addr_hit(reg_addr, `CIS_OFF_REF_FLAGS);
  assign wr_pll_flags = reg_wr && addr_hit(reg_addr, `CIS_OFF_PLL_FLAGS);
  assign wr_ref_en    = reg_wr && addr_hit(reg_addr, `CIS_OFF_REF_EN);
  assign wr_pll_en    = reg_wr && addr_hit(reg_addr, `CIS_OFF_PLL_EN);
  assign wr_rev_ext   = reg_wr && addr_hit(reg_addr, `CIS_OFF_REV_EXT);

  // RULE10 write-one-to-clear masks
  assign clr_ref_flags = {2{wr_ref_flags}} & reg_wdata[`CIS_BIT_B:`CIS_BIT_A];
  assign clr_pll_flags = {2{wr_pll_flags}} & reg_wdata[`CIS_BIT_B:`CIS_BIT_A];

  // RULE4 RULE5 RULE8 masked reference set
  assign next_ref_flags = flag_update(input_failure_flags, clr_ref_flags,
                                      ref_rise, input_failure_enable);
  // RULE6 RULE7 RULE9 masked pll set
  assign next_pll_flags = flag_update(loop_flags, clr_pll_flags,
                                      pll_rise, loop_enable);

  // RULE8 RULE9 enable registers
  // an event that arrives while its enable is low is lost, not queued
  always @(posedge mclk) begin
    if (srst) begin
      input_failure_enable <= `CIS_EN_RST;
      loop_enable          <= `CIS_EN_RST;
    end else if (ce) begin
      if (wr_ref_en)
        input_failure_enable <= reg_wdata[`CIS_BIT_B:`CIS_BIT_A];
      else if (wr_pll_en)
        loop_enable <= reg_wdata[`CIS_BIT_B:`CIS_BIT_A];
    end
  end

  // RULE10 sticky flags
  // a failure held high sets its flag once; only a new rising edge sets it again
  always @(posedge mclk) begin
    if (srst) begin
      input_failure_flags <= `CIS_FLAG_RST;
      loop_flags          <= `CIS_FLAG_RST;
    end else if (ce) begin
      input_failure_flags <= next_ref_flags;
      loop_flags          <= next_pll_flags;
    end
  end

  // revision extension; host-writable, back to its default on reset
  always @(posedge mclk) begin
    if (srst) begin
      rev_ext <= `CIS_REV_EXT_RST;
    end else if (ce && wr_rev_ext) begin
      rev_ext <= reg_wdata;
    end
  end

  // ****************************************************
  // interrupt request
  // ****************************************************
  wire [1:0] ref_pending;
  wire [1:0] pll_pending;

  // RULE10 irq while any enabled flag set
  // combinational from the flag registers, so it falls one cycle after the clearing write; the enable
  // is applied again so masking a set flag also quiets the line
  assign ref_pending = input_failure_flags & input_failure_enable;
  assign pll_pending = loop_flags & loop_enable;
  assign irq         = |{ref_pending, pll_pending};

  // ****************************************************
  // read path
  // ****************************************************
  reg  [7:0] next_rdata;

  // read mux; reserved bits and unmapped offsets read as zero
  always @* begin
    next_rdata = `CIS_RDATA_RST;
    // RULE1 identity and revision
    if (addr_hit(reg_addr, `CIS_OFF_IDENT))
      next_rdata = {ready, REVISION, PART_ID};
    else if (addr_hit(reg_addr, `CIS_OFF_REF_FLAGS))
      next_rdata = {`CIS_RSV_ZERO, input_failure_flags};
    else if (addr_hit(reg_addr, `CIS_OFF_PLL_FLAGS))
      next_rdata = {`CIS_RSV_ZERO, loop_flags};
    else if (addr_hit(reg_addr, `CIS_OFF_REF_EN))
      next_rdata = {`CIS_RSV_ZERO, input_failure_enable};
    else if (addr_hit(reg_addr, `CIS_OFF_PLL_EN))
      next_rdata = {`CIS_RSV_ZERO, loop_enable};
    else if (addr_hit(reg_addr, `CIS_OFF_REV_EXT))
      next_rdata = rev_ext;
  end

  // registered read data, one cycle after reg_rd; holds until the next read
  // so a slow host may pick it up late
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= `CIS_RDATA_RST;
    end else if (ce && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // cis_ident_irq

// ---- verif/cis_checker.sv ----
`timescale 1ns/100ps
// watches the register port and irq
module cis_checker #(
  parameter [4:0] PART_ID  = 5'h0A, // arbitrary value
  parameter [1:0] REVISION = 2'h0
) (
  // clock, reset, enable
  input wire       mclk,
  input wire       srst,
  input wire       ce,
  // register port
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // events and request
  input wire       ref_a_fail,
  input wire       ref_b_fail,
  input wire       pll_holdover,
  input wire       pll_unlock,
  input wire       irq
);
  reg [3:0] en;
  // shadow of both enable registers, needed to judge irq
  always @(posedge mclk) begin
    if (srst) en <= 4'h0;
    else if (ce && reg_wr && reg_addr[7:1] == 7'h02) en[{reg_addr[0], 1'b0} +: 2] <= reg_wdata[1:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_a_raises: assert property ($rose(ref_a_fail) && en[0] |-> ##[2:4] irq) else $error("no irq on a");
  a_b_raises: assert property ($rose(ref_b_fail) && en[1] |-> ##[2:4] irq) else $error("no irq on b");
  a_hold_raises: assert property ($rose(pll_holdover) && en[2] |-> ##[2:4] irq) else $error("no irq hold");
  a_lock_raises: assert property ($rose(pll_unlock) && en[3] |-> ##[2:4] irq) else $error("no irq lock");
  a_irq_enabled: assert property (irq |-> en != 4'h0) else $error("irq while disabled");
  a_irq_sticky: assert property (irq && !reg_wr |=> irq) else $error("irq dropped");
  a_resv_zero: assert property (reg_rd && reg_addr[7:3] == 5'h00 && reg_addr[2] != reg_addr[1]
    |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
  a_ident_field: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[6:0] == {REVISION, PART_ID})
    else $error("identity wrong");
endmodule // cis_checker
bind cis_ident_irq cis_checker #(.PART_ID(PART_ID), .REVISION(REVISION)) i_chk (.mclk(mclk), .srst(srst), .ce(ce),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ref_a_fail(ref_a_fail), .ref_b_fail(ref_b_fail), .pll_holdover(pll_holdover), .pll_unlock(pll_unlock), .irq(irq));

// ---- verif/cis_host.sv ----
`timescale 1ns/100ps
// host side of the register port
module cis_host (
  // clock
  input wire        mclk,
  // register port
  output reg  [7:0] reg_addr  = 8'h00,
  output reg        reg_wr    = 1'b0,
  output reg        reg_rd    = 1'b0,
  output reg  [7:0] reg_wdata = 8'h00,
  input  wire [7:0] reg_rdata
);
  // one-cycle write strobe, data scrambled on release
  task wr(input [7:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // data is taken late since it holds until next read
  task rd(input [7:0] a, output [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask
  task wait_ready(input integer pause, output [7:0] d);
    integer n;
    d = 8'h00;
    repeat (pause) @(posedge mclk);
    for (n = 0; n < 20 && !d[7]; n = n + 1) rd(8'h00, d);
  endtask
endmodule // cis_host

// ---- verif/tb_cis_ident_irq.sv ----
`timescale 1ns/100ps
module tb_cis_ident_irq;
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg         ce   = 1'h1;
  reg  [3:0]  ev = 4'h0;
  reg  [7:0]  d, ea, ep;
  wire [7:0]  addr, wdata, rdata;
  wire        wr, rd, irq;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     i;
  // short ready delay keeps the run brief
  cis_ident_irq #(.READY_CYCLES(24'd20)) i_dut (.mclk(mclk), .srst(srst), .ce(ce), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .ref_a_fail(ev[0]), .ref_b_fail(ev[1]),
    .pll_holdover(ev[2]), .pll_unlock(ev[3]), .irq(irq));
  cis_host i_host (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));
  // 200 MHz clock
  initial forever #2.5 mclk = ~mclk;
  task chk(input string n, input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, run needs under two hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    i_host.wait_ready(20, d);
    chk("ident", 8'h8A, d);
    i_host.wr(8'h00, 8'h55);
    i_host.rd(8'h00, d);
    chk("ident ro", 8'h8A, d);
    i_host.rd(8'hC6, d);
    chk("rev ext", 8'h03, d);
    $display("test ident done");
    // one enable per pass, last pass all off
    for (i = 0; i < 5; i = i + 1) begin
      ea = (8'h01 << i) & 8'h03;
      ep = ((8'h01 << i) >> 2) & 8'h03;
      i_host.wr(8'h04, ea);
      i_host.wr(8'h05, ep);
      ev <= 4'hF;
      repeat (3) @(posedge mclk);
      ev <= 4'h0;
      repeat (4) @(posedge mclk);
      i_host.rd(8'h02, d);
      chk("ref flags", ea, d);
      i_host.rd(8'h03, d);
      chk("pll flags", ep, d);
      chk("irq on", {7'h00, i < 4}, {7'h00, irq});
      i_host.wr(8'h02, 8'hFF);
      i_host.wr(8'h03, 8'hFF);
      #1 chk("irq off", 8'h00, {7'h00, irq});
    end
    $display("test events done");
    // clock enable low: a write must not land
    @(posedge mclk);
    ce <= 1'h0;
    i_host.wr(8'h04, 8'h03);
    ce <= 1'h1;
    i_host.rd(8'h04, d);
    chk("enable frozen", 8'h00, d);
    $display("test enable done");
    // revision extension is writable and returns to its default on reset
    i_host.wr(8'hC6, 8'h5A);
    i_host.rd(8'hC6, d);
    chk("rev ext rw", 8'h5A, d);
    @(posedge mclk);
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    i_host.rd(8'hC6, d);
    chk("rev ext reset", 8'h03, d);
    i_host.rd(8'h00, d);
    chk("not ready", 8'h0A, d);
    i_host.wait_ready(20, d);
    chk("ready again", 8'h8A, d);
    $display("test reset done");
    complete_run;
  end
endmodule // tb_cis_ident_irq
